// ==== rtl/sielp_top.sv ====
// Exception priority, break flag protection, wait/stop control and reset cause register.
`timescale 1ns/10ps
module sielp_top #(
    parameter int RecLong = sielp_pkg::REC_LONG // Long stop recovery count, shortened in simulation.
) (
    input wire logic mclk, // Quad-rate bus clock, 50 MHz.
    input wire logic reset_n, // Asynchronous reset, active low.
    input wire logic clkEn, // Clock enable; low freezes all state.
    input wire logic quadFall, // One-cycle strobe marking a quad-clock falling edge.
    input wire logic irqReq, // IRQ pin request, synchronised pin level.
    input wire logic tch0Req, // Timer channel 0 request.
    input wire logic tch1Req, // Timer channel 1 request.
    input wire logic tovfReq, // Timer overflow request.
    input wire logic kbdReq, // Keyboard request.
    input wire logic adcReq, // ADC conversion complete request.
    input wire logic swiExec, // Software interrupt instruction executed, pulse.
    input wire logic iMask, // Global interrupt mask bit from the CPU.
    input wire logic breakReq, // Break module output, level.
    input wire logic waitExec, // Wait instruction executed, pulse.
    input wire logic stopExec, // Stop instruction executed, pulse.
    input wire logic porEvt, // Power-on reset event, pulse.
    input wire logic pinRstEvt, // External reset pin event, pulse.
    input wire logic wdogEvt, // Watchdog timeout, pulse.
    input wire logic badOpEvt, // Illegal opcode, pulse.
    input wire logic badAdrEvt, // Opcode fetch from unimplemented address, pulse.
    input wire logic lowVEvt, // Low-voltage inhibit, pulse.
    input wire logic monEntryEvt, // Monitor entry on erased reset vector, pulse.
    input wire logic flagClrStep1, // First step of a peripheral two-step clear, pulse.
    input wire logic flagClrStep2, // Second step of a peripheral two-step clear, pulse.
    output logic takeIntr, // Exception taken this cycle, pulse.
    output logic [15:0] vecAddr, // Low byte address of the vector to fetch.
    output logic clearIMask, // Clears the CPU global mask, pulse.
    output logic cpuClkEn, // CPU clock gate.
    output logic periphClkEn, // Peripheral clock gate.
    output logic busX2En, // Double-rate bus clock enable.
    output logic busX4En, // Quad-rate bus clock enable.
    output logic wdogEn, // Watchdog counting enable.
    output logic flagClrAllow, // Peripherals may clear their status flags.
    output logic flagClrDo, // Completed two-step clear, pulse.
    output logic [1:0] lpState, // Low-power state code.
    input wire logic [7:0] s_axi_awaddr, // AXI write address.
    input wire logic s_axi_awvalid, // AXI write address valid.
    output logic s_axi_awready, // AXI write address ready.
    input wire logic [31:0] s_axi_wdata, // AXI write data.
    input wire logic [3:0] s_axi_wstrb, // AXI write strobes.
    input wire logic s_axi_wvalid, // AXI write data valid.
    output logic s_axi_wready, // AXI write data ready.
    output logic [1:0] s_axi_bresp, // AXI write response.
    output logic s_axi_bvalid, // AXI write response valid.
    input wire logic s_axi_bready, // AXI write response ready.
    input wire logic [7:0] s_axi_araddr, // AXI read address.
    input wire logic s_axi_arvalid, // AXI read address valid.
    output logic s_axi_arready, // AXI read address ready.
    output logic [31:0] s_axi_rdata, // AXI read data.
    output logic [1:0] s_axi_rresp, // AXI read response.
    output logic s_axi_rvalid, // AXI read data valid.
    input wire logic s_axi_rready // AXI read data ready.
);
    // The recovery counter must reach the long count.
    initial begin
        if (RecLong < sielp_pkg::REC_SHORT || RecLong > 65535) begin
            $error("RecLong out of range");
        end
    end

    // All block state in one packed struct.
    typedef struct packed {
        sielp_pkg::sielp_lp_t lp; // Low-power state.
        logic [15:0] cnt; // Unit counter for recovery timing.
        logic wakeIntr; // Recovery was started by an interrupt.
        logic wakeDly; // Stack one cycle after wait wake.
        logic [7:0] rc; // Reset cause flags.
        logic [7:0] cfg; // Configuration bits.
        logic break_flag_clear_enable; // Break flag clear enable.
        logic bsw; // Break during low power flag.
        logic step1; // First clear step seen.
        logic brkQ; // Break level of the last cycle, for edge detection.
        logic takeIntr; // Registered take strobe.
        logic [15:0] vec; // Registered vector.
        logic clrI; // Registered mask clear.
        logic flagDo; // Registered two-step clear completion.
        logic haveW; // Write address held.
        logic haveD; // Write data held.
        logic [7:0] wa; // Held write address.
        logic [31:0] wd; // Held write data.
        logic bv; // Write response valid.
        logic [1:0] br; // Write response code.
        logic rv; // Read response valid.
        logic [31:0] rd; // Read data.
        logic [1:0] rr; // Read response code.
    } sielp_state_t;

    sielp_state_t st_reg;
    sielp_state_t st_next;
    logic [7:0] ips1; // Interrupt pending status 1.
    logic [7:0] ips2; // Interrupt pending status 2.
    logic [7:0] ips3; // Interrupt pending status 3.
    logic anyMaskable; // Some maskable request pending.
    logic inBreak; // Break is active.
    logic [15:0] recLen; // Selected recovery length.

    // Pending requests are mirrored live; nothing software writes reaches them.
    always_comb begin
        ips1 = 8'h00;
        ips2 = 8'h00;
        ips3 = 8'h00;
        // Flag n sits at bit n+1 of status 1, bit n-7 of status 2 and bit n-15 of status 3.
        ips1[sielp_pkg::IRQ_BIT + 1] = irqReq;
        ips1[sielp_pkg::TCH0_BIT + 1] = tch0Req;
        ips1[sielp_pkg::TCH1_BIT + 1] = tch1Req;
        ips1[sielp_pkg::TOVF_BIT + 1] = tovfReq;
        ips2[sielp_pkg::KBD_BIT - 7] = kbdReq;
        ips3[sielp_pkg::ADC_BIT - 15] = adcReq;
    end

    assign anyMaskable = irqReq | tch0Req | tch1Req | tovfReq | kbdReq | adcReq;
    assign inBreak = breakReq;
    assign recLen = st_reg.cfg[sielp_pkg::CFG_SHORT_STOP_RECOVERY] ? 16'(sielp_pkg::REC_SHORT) : 16'(RecLong);

    // Next-state logic for the whole block.
    always_comb begin
        logic rdRc;
        logic wrDo;
        logic wake;
        logic bswSet;
        logic [15:0] pvec;
        rdRc = 1'b0;
        wrDo = 1'b0;
        wake = 1'b0;
        bswSet = 1'b0;
        pvec = sielp_pkg::VEC_ADC;
        st_next = st_reg;
        st_next.takeIntr = 1'b0;
        st_next.clrI = 1'b0;
        st_next.flagDo = 1'b0;

        // Exception selection; reset sources never reach here, they reset the CPU together.
        if (irqReq) begin
            pvec = sielp_pkg::VEC_IRQ;
        end else if (tch0Req) begin
            pvec = sielp_pkg::VEC_TCH0;
        end else if (tch1Req) begin
            pvec = sielp_pkg::VEC_TCH1;
        end else if (tovfReq) begin
            pvec = sielp_pkg::VEC_TOVF;
        end else if (kbdReq) begin
            pvec = sielp_pkg::VEC_KBD;
        end
        // Break enters once on its rising edge; a held level would re-enter every cycle.
        st_next.brkQ = inBreak;
        if (swiExec || (inBreak && !st_reg.brkQ)) begin
            st_next.takeIntr = 1'b1;
            st_next.vec = sielp_pkg::VEC_SWI;
        end else if (!iMask && anyMaskable && st_reg.lp == sielp_pkg::LP_RUN && !st_reg.wakeDly &&
                     !st_reg.takeIntr) begin
            // The core sets its mask only after it sees a take, so the cycle after one is skipped.
            st_next.takeIntr = 1'b1;
            st_next.vec = pvec;
        end
        if (st_reg.wakeDly) begin
            st_next.wakeDly = 1'b0;
        end

        // Low-power sequencing.
        wake = (anyMaskable && !iMask) || inBreak;
        case (st_reg.lp)
            sielp_pkg::LP_RUN: begin
                if (waitExec) begin
                    st_next.lp = sielp_pkg::LP_WAIT;
                    st_next.clrI = 1'b1;
                end else if (stopExec) begin
                    st_next.lp = sielp_pkg::LP_STOP;
                    st_next.clrI = 1'b1;
                    st_next.cnt = 16'h0000;
                end
            end
            sielp_pkg::LP_WAIT: begin
                if (wake) begin
                    st_next.lp = sielp_pkg::LP_RUN;
                    st_next.wakeDly = 1'b1;
                    if (inBreak) begin
                        st_next.bsw = 1'b1;
                        st_next.vec = sielp_pkg::VEC_SWI;
                        bswSet = 1'b1;
                    end else begin
                        st_next.vec = pvec;
                    end
                end
            end
            sielp_pkg::LP_STOP: begin
                st_next.cnt = 16'h0000;
                if (wake) begin
                    st_next.lp = sielp_pkg::LP_REC;
                    st_next.wakeIntr = !inBreak;
                    if (inBreak) begin
                        st_next.bsw = 1'b1;
                        bswSet = 1'b1;
                    end
                end
            end
            default: begin
                if (quadFall) begin
                    st_next.cnt = st_reg.cnt + 16'h0001;
                end
                // Leave on the strobe that completes the count, so recovery spans recLen strobes.
                if (quadFall && st_reg.cnt >= recLen - 16'h0001) begin
                    st_next.lp = sielp_pkg::LP_RUN;
                    st_next.cnt = 16'h0000;
                end
            end
        endcase

        // Two-step clear: first step is remembered; the second completes out of break, or in break with break_flag_clear_enable set.
        if (flagClrStep1) begin
            st_next.step1 = 1'b1;
        end
        if (flagClrStep2 && st_reg.step1 && (!inBreak || st_reg.break_flag_clear_enable)) begin
            st_next.flagDo = 1'b1;
            st_next.step1 = 1'b0;
        end

        // AXI write path: address and data in either order.
        if (s_axi_awvalid && !st_reg.haveW) begin
            st_next.haveW = 1'b1;
            st_next.wa = s_axi_awaddr;
        end
        if (s_axi_wvalid && !st_reg.haveD) begin
            st_next.haveD = 1'b1;
            st_next.wd = s_axi_wdata;
        end
        if (st_reg.haveW && st_reg.haveD && !st_reg.bv) begin
            wrDo = s_axi_wstrb[0] | 1'b1;
            st_next.haveW = 1'b0;
            st_next.haveD = 1'b0;
            st_next.bv = 1'b1;
            st_next.br = 2'b00;
            if (st_reg.wa == sielp_pkg::BFC_OFF) begin
                st_next.break_flag_clear_enable = st_reg.wd[7];
            end else if (st_reg.wa == sielp_pkg::CFG_OFF) begin
                st_next.cfg = st_reg.wd[7:0];
            end else if (st_reg.wa == sielp_pkg::BST_OFF) begin
                st_next.bsw = st_reg.bsw & st_reg.wd[1];
            end else if (st_reg.wa == sielp_pkg::IPS1_OFF || st_reg.wa == sielp_pkg::IPS2_OFF ||
                         st_reg.wa == sielp_pkg::IPS3_OFF || st_reg.wa == sielp_pkg::RCS_OFF) begin
                st_next.br = 2'b00;
            end else begin
                st_next.br = 2'b10;
            end
        end
        if (st_reg.bv && s_axi_bready) begin
            st_next.bv = 1'b0;
        end
        // A break in low power outranks a software clear of its flag in the same cycle.
        if (bswSet) begin
            st_next.bsw = 1'b1;
        end

        // AXI read path.
        if (s_axi_arvalid && !st_reg.rv) begin
            st_next.rv = 1'b1;
            st_next.rr = 2'b00;
            st_next.rd = 32'h0000_0000;
            if (s_axi_araddr == sielp_pkg::IPS1_OFF) begin
                st_next.rd[7:0] = ips1;
            end else if (s_axi_araddr == sielp_pkg::IPS2_OFF) begin
                st_next.rd[7:0] = ips2;
            end else if (s_axi_araddr == sielp_pkg::IPS3_OFF) begin
                st_next.rd[7:0] = ips3;
            end else if (s_axi_araddr == sielp_pkg::RCS_OFF) begin
                st_next.rd[7:0] = st_reg.rc;
                rdRc = 1'b1;
            end else if (s_axi_araddr == sielp_pkg::BFC_OFF) begin
                st_next.rd[7] = st_reg.break_flag_clear_enable;
            end else if (s_axi_araddr == sielp_pkg::BST_OFF) begin
                st_next.rd[1] = st_reg.bsw;
            end else if (s_axi_araddr == sielp_pkg::CFG_OFF) begin
                st_next.rd[7:0] = st_reg.cfg;
            end else begin
                st_next.rr = 2'b10;
            end
        end
        if (st_reg.rv && s_axi_rready) begin
            st_next.rv = 1'b0;
        end

        // Reset cause: a read clears, but an event in the same cycle still sets.
        if (rdRc) begin
            st_next.rc = 8'h00;
        end
        if (porEvt) begin
            st_next.rc = sielp_pkg::RC_RESET;
        end else begin
            if (pinRstEvt) st_next.rc[sielp_pkg::RC_PIN] = 1'b1;
            if (wdogEvt) st_next.rc[sielp_pkg::RC_WDOG] = 1'b1;
            if (badOpEvt) st_next.rc[sielp_pkg::RC_BADOP] = 1'b1;
            if (badAdrEvt) st_next.rc[sielp_pkg::RC_BADADR] = 1'b1;
            if (lowVEvt) st_next.rc[sielp_pkg::RC_LOWV] = 1'b1;
            if (monEntryEvt) st_next.rc[sielp_pkg::RC_MON] = 1'b1;
        end
        if (wrDo) begin
            st_next.wd = st_next.wd;
        end
    end

    // State register; the clock enable freezes everything.
    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            st_reg <= '0;
            st_reg.rc <= sielp_pkg::RC_RESET;
            st_reg.cfg <= sielp_pkg::CFG_RESET;
            st_reg.vec <= sielp_pkg::VEC_RESET;
        end else if (clkEn) begin
            st_reg <= st_next;
        end
    end

    // Output decode.
    assign takeIntr = st_reg.takeIntr | st_reg.wakeDly;
    assign vecAddr = st_reg.vec;
    assign clearIMask = st_reg.clrI;
    assign lpState = st_reg.lp;
    assign cpuClkEn = (st_reg.lp == sielp_pkg::LP_RUN);
    assign periphClkEn = (st_reg.lp != sielp_pkg::LP_STOP);
    assign busX4En = (st_reg.lp != sielp_pkg::LP_STOP);
    assign busX2En = (st_reg.lp != sielp_pkg::LP_STOP) || st_reg.cfg[sielp_pkg::CFG_OSCSTOP];
    assign wdogEn = !st_reg.cfg[sielp_pkg::CFG_WDIS] && (st_reg.lp != sielp_pkg::LP_STOP);
    assign flagClrAllow = !inBreak || st_reg.break_flag_clear_enable;
    assign flagClrDo = st_reg.flagDo;
    assign s_axi_awready = !st_reg.haveW;
    assign s_axi_wready = !st_reg.haveD;
    assign s_axi_bvalid = st_reg.bv;
    assign s_axi_bresp = st_reg.br;
    assign s_axi_arready = !st_reg.rv;
    assign s_axi_rvalid = st_reg.rv;
    assign s_axi_rdata = st_reg.rd;
    assign s_axi_rresp = st_reg.rr;

    // Checks next to the logic.
    a_swi_vector: assert property (@(posedge mclk) disable iff (!reset_n)
        clkEn && swiExec |=> takeIntr && vecAddr == sielp_pkg::VEC_SWI) else $error("swi vector wrong");
    a_irq_masked: assert property (@(posedge mclk) disable iff (!reset_n)
        clkEn && iMask && !swiExec && !breakReq && !st_reg.wakeDly |=> !takeIntr) else $error("masked taken");
    a_status_low: assert property (@(posedge mclk) disable iff (!reset_n)
        ips1[1:0] == 2'b00) else $error("low bits set");
    a_wait_clr: assert property (@(posedge mclk) disable iff (!reset_n)
        clkEn && waitExec && lpState == 2'b00 |=> clearIMask && !cpuClkEn) else $error("wait entry");
    a_stop_clocks: assert property (@(posedge mclk) disable iff (!reset_n)
        lpState == 2'b10 |-> !busX4En && wdogEn == 1'b0) else $error("stop clocks");
    a_stop_hold: assert property (@(posedge mclk) disable iff (!reset_n)
        lpState == 2'b10 && clkEn |=> st_reg.cnt == 16'h0000) else $error("counter not held");
    a_rc_read: assert property (@(posedge mclk) disable iff (!reset_n)
        clkEn && s_axi_arvalid && !st_reg.rv && s_axi_araddr == sielp_pkg::RCS_OFF && !porEvt && !pinRstEvt &&
        !wdogEvt && !badOpEvt && !badAdrEvt && !lowVEvt && !monEntryEvt |=> st_reg.rc == 8'h00)
        else $error("rc not cleared");
    a_por_only: assert property (@(posedge mclk) disable iff (!reset_n)
        clkEn && porEvt |=> st_reg.rc == sielp_pkg::RC_RESET) else $error("por flags");
    a_break_prot: assert property (@(posedge mclk) disable iff (!reset_n)
        breakReq && !st_reg.break_flag_clear_enable |-> !flagClrAllow) else $error("break protect");
    c_wait_wake: cover property (@(posedge mclk) lpState == 2'b01 ##1 lpState == 2'b00);
    c_stop_rec: cover property (@(posedge mclk) lpState == 2'b11 ##1 lpState == 2'b00);
    c_rc_read: cover property (@(posedge mclk) s_axi_rvalid && st_reg.rd[7]);
endmodule : sielp_top

// ==== rtl/sielp_pkg.sv ====
// Package with register map, field layout, vectors and timing constants for the exception/low-power unit.
package sielp_pkg;
    // Register byte offsets on the AXI4-Lite slave.
    localparam logic [7:0] IPS1_OFF = 8'h00;
    localparam logic [7:0] IPS2_OFF = 8'h04;
    localparam logic [7:0] IPS3_OFF = 8'h08;
    localparam logic [7:0] RCS_OFF = 8'h0c;
    localparam logic [7:0] BFC_OFF = 8'h10;
    localparam logic [7:0] BST_OFF = 8'h14;
    localparam logic [7:0] CFG_OFF = 8'h18;
    // Pending flag numbers, mapped into the three status registers by sielp_top.
    localparam int IRQ_BIT = 1;
    localparam int TCH0_BIT = 3;
    localparam int TCH1_BIT = 4;
    localparam int TOVF_BIT = 5;
    localparam int KBD_BIT = 14;
    localparam int ADC_BIT = 15;
    // Reset cause field positions.
    localparam int RC_POR = 7;
    localparam int RC_PIN = 6;
    localparam int RC_WDOG = 5;
    localparam int RC_BADOP = 4;
    localparam int RC_BADADR = 3;
    localparam int RC_MON = 1;
    localparam int RC_LOWV = 0;
    // Configuration register fields.
    localparam int CFG_WDIS = 0;
    localparam int CFG_SHORT_STOP_RECOVERY = 1;
    localparam int CFG_OSCSTOP = 2;
    // Low word of each two-byte vector, highest priority first.
    localparam logic [15:0] VEC_RESET = 16'hfffe;
    localparam logic [15:0] VEC_SWI = 16'hfffc;
    localparam logic [15:0] VEC_IRQ = 16'hfffa;
    localparam logic [15:0] VEC_TCH0 = 16'hfff6;
    localparam logic [15:0] VEC_TCH1 = 16'hfff4;
    localparam logic [15:0] VEC_TOVF = 16'hfff2;
    localparam logic [15:0] VEC_KBD = 16'hffe0;
    localparam logic [15:0] VEC_ADC = 16'hffde;
    // Reset values.
    localparam logic [7:0] RC_RESET = 8'h80;
    localparam logic [7:0] CFG_RESET = 8'h00;
    // Stop recovery lengths in quad-rate cycles.
    localparam int REC_LONG = 4096;
    localparam int REC_SHORT = 32;
    // Low-power state encoding.
    typedef enum logic [1:0] {
        LP_RUN = 2'b00,
        LP_WAIT = 2'b01,
        LP_STOP = 2'b10,
        LP_REC = 2'b11
    } sielp_lp_t;
endpackage : sielp_pkg

// ==== verif/sielp_cpu_model.sv ====
// Core-side partner model: global interrupt mask and quad-clock falling-edge strobe.
`timescale 1ns/10ps
module sielp_cpu_model (
    input wire logic mclk, // Quad-rate clock.
    input wire logic reset_n, // Asynchronous reset, active low.
    input wire logic takeIntr, // Exception entry from the unit.
    input wire logic clearIMask, // Mask clear on wait or stop.
    input wire logic unmask, // Bench pulse that clears the mask, as software would.
    output logic iMask, // Global interrupt mask.
    output logic quadFall // One falling-edge strobe per quad clock cycle.
);
    // The core sets the mask on every entry, so a held request is taken only once.
    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            iMask <= 1'b1; // The core leaves reset masked.
            quadFall <= 1'b0;
        end else begin
            quadFall <= 1'b1; // The oscillator runs free, so every cycle has a falling edge.
            if (takeIntr) begin
                iMask <= 1'b1;
            end else if (clearIMask || unmask) begin
                iMask <= 1'b0;
            end
        end
    end
endmodule : sielp_cpu_model

// ==== verif/tb_top.sv ====
// Self-checking testbench for the exception, low-power and reset-cause unit.
`timescale 1ns/10ps
module tb_top;
    localparam int RecL = 40; // Shortened long recovery keeps the run brief.
    logic mclk, reset_n, clkEn, iMask, quadFall, breakReq, takeIntr, clearIMask; // Clock, reset and core signals.
    logic cpuClkEn, periphClkEn, busX2En, busX4En, wdogEn, flagClrAllow, flagClrDo; // Gates and flag control.
    logic [5:0] req; // Requests: irq, ch0, ch1, overflow, keyboard, adc.
    logic [12:0] pul; // Pulses: seven reset events, swi, wait, stop, two clear steps, unmask.
    logic [15:0] vecAddr, lastVec; // Vector output and the last one taken.
    logic [1:0] lpState, r, s_axi_bresp, s_axi_rresp; // State and bus responses.
    logic [31:0] d, s_axi_wdata, s_axi_rdata; // Bus data.
    logic [7:0] s_axi_awaddr, s_axi_araddr; // Bus addresses.
    logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready; // Write side.
    logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready; // Read side.
    int fails, nCompared, nTake, nDo, nClr, n0, cnt; // Counters.
    int rcPos[7] = '{sielp_pkg::RC_POR, sielp_pkg::RC_PIN, sielp_pkg::RC_WDOG, sielp_pkg::RC_BADOP,
        sielp_pkg::RC_BADADR, sielp_pkg::RC_LOWV, sielp_pkg::RC_MON}; // Cause bit of each event pulse.
    logic [15:0] vecTab[6] = '{sielp_pkg::VEC_IRQ, sielp_pkg::VEC_TCH0, sielp_pkg::VEC_TCH1,
        sielp_pkg::VEC_TOVF, sielp_pkg::VEC_KBD, sielp_pkg::VEC_ADC}; // Vectors, highest priority first.
    sielp_top #(.RecLong(RecL)) dut_u (.mclk, .reset_n, .clkEn, .quadFall, .irqReq(req[0]),
        .tch0Req(req[1]), .tch1Req(req[2]), .tovfReq(req[3]), .kbdReq(req[4]), .adcReq(req[5]), .iMask,
        .swiExec(pul[7]), .breakReq, .waitExec(pul[8]), .stopExec(pul[9]), .porEvt(pul[0]), .pinRstEvt(pul[1]),
        .wdogEvt(pul[2]), .badOpEvt(pul[3]), .badAdrEvt(pul[4]), .lowVEvt(pul[5]), .monEntryEvt(pul[6]),
        .flagClrStep1(pul[10]), .flagClrStep2(pul[11]), .takeIntr, .vecAddr, .clearIMask, .cpuClkEn,
        .periphClkEn, .busX2En, .busX4En, .wdogEn, .flagClrAllow, .flagClrDo, .lpState, .s_axi_awaddr,
        .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb(4'hf), .s_axi_wvalid, .s_axi_wready,
        .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
        .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready);
    sielp_cpu_model cpu_u (.mclk, .reset_n, .takeIntr, .clearIMask, .unmask(pul[12]), .iMask, .quadFall);
    // Free-running 50 MHz clock.
    initial begin
        mclk = 1'b0;
        forever #10 mclk = ~mclk;
    end
    // Tally the unit's one-cycle pulses, which the main sequence cannot watch itself.
    always @(posedge mclk) begin
        if (takeIntr === 1'b1) begin
            nTake++;
            lastVec = vecAddr;
        end
        nDo += (flagClrDo === 1'b1);
        nClr += (clearIMask === 1'b1);
    end
    // The whole sequence needs a few hundred cycles, so ten thousand marks a hang.
    initial begin
        #200000;
        fails++;
        finish_test();
    end
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        nCompared++;
        if (got !== exp) begin
            fails++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk
    // Write address and data go out together; each is released once taken.
    task automatic wr(input logic [7:0] a, input logic [31:0] v);
        @(posedge mclk);
        s_axi_awaddr <= a;
        s_axi_wdata <= v;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        do begin
            @(posedge mclk);
            if (s_axi_awready === 1'b1) s_axi_awvalid <= 1'b0;
            if (s_axi_wready === 1'b1) s_axi_wvalid <= 1'b0;
        end while (s_axi_bvalid !== 1'b1);
        r = s_axi_bresp;
        s_axi_bready <= 1'b0;
    endtask : wr
    task automatic rd(input logic [7:0] a);
        @(posedge mclk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        do begin
            @(posedge mclk);
            if (s_axi_arready === 1'b1) s_axi_arvalid <= 1'b0;
        end while (s_axi_rvalid !== 1'b1);
        d = s_axi_rdata;
        r = s_axi_rresp;
        s_axi_rready <= 1'b0;
    endtask : rd
    task automatic pulse(input logic [12:0] m);
        @(posedge mclk);
        pul <= m;
        @(posedge mclk);
        pul <= '0;
    endtask : pulse
    // Pulse, then wait for the next exception entry and check its vector.
    task automatic take(input logic [12:0] m, input logic [15:0] v);
        n0 = nTake;
        pulse(m);
        while (nTake == n0) @(posedge mclk);
        chk(lastVec, v);
    endtask : take
    task automatic finish_test();
        $display("compared %0d, failed %0d", nCompared, fails);
        if (fails == 0 && nCompared > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask : finish_test
    // Main sequence: reset cause, status flags, priority, break, wait and stop.
    initial begin
        {reset_n, req, pul, breakReq, s_axi_awvalid, s_axi_wvalid, s_axi_bready} = '0;
        {s_axi_arvalid, s_axi_rready, s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
        clkEn = 1'b1;
        repeat (10) @(posedge mclk);
        reset_n <= 1'b1;
        rd(sielp_pkg::RCS_OFF);
        chk(d, 32'h80);
        rd(sielp_pkg::RCS_OFF);
        chk(d, 32'h0);
        for (int i = 1; i < 7; i++) begin
            pulse(13'h1 << i);
            rd(sielp_pkg::RCS_OFF);
            chk(d, 32'h1 << rcPos[i]);
        end
        pulse(13'h6);
        rd(sielp_pkg::RCS_OFF);
        chk(d, 32'h60);
        pulse(13'h21);
        rd(sielp_pkg::RCS_OFF);
        chk(d, 32'h80);
        // All requests pending while masked: flags show, nothing is taken.
        @(posedge mclk) req <= 6'h3f;
        n0 = nTake;
        rd(sielp_pkg::IPS1_OFF);
        chk(d, 32'h74);
        chk(nTake, n0);
        rd(sielp_pkg::IPS2_OFF);
        chk(d, 32'h80);
        rd(sielp_pkg::IPS3_OFF);
        chk(d, 32'h1);
        wr(sielp_pkg::IPS1_OFF, 32'h0);
        chk(r, 2'h0);
        rd(sielp_pkg::IPS1_OFF);
        chk(d, 32'h74);
        rd(8'h40);
        chk({d[29:0], r}, 32'h2); // Unmapped place.
        for (int i = 0; i < 6; i++) begin
            @(posedge mclk) req <= 6'h3f << i;
            take(13'h1000, vecTab[i]);
        end
        @(posedge mclk) req <= '0;
        take(13'h80, sielp_pkg::VEC_SWI);
        // A two-step clear begun before break must wait for break to end.
        pulse(13'h400);
        n0 = nDo;
        lastVec = '0;
        @(posedge mclk) breakReq <= 1'b1;
        repeat (3) @(posedge mclk);
        chk(lastVec, sielp_pkg::VEC_SWI);
        chk(flagClrAllow, 32'h0);
        pulse(13'h800);
        repeat (2) @(posedge mclk);
        chk(nDo, n0);
        @(posedge mclk) breakReq <= 1'b0;
        pulse(13'h800);
        repeat (2) @(posedge mclk);
        chk(nDo, n0 + 1);
        wr(sielp_pkg::BFC_OFF, 32'h80);
        @(posedge mclk) breakReq <= 1'b1;
        repeat (3) @(posedge mclk);
        chk(flagClrAllow, 32'h1);
        @(posedge mclk) breakReq <= 1'b0;
        n0 = nClr;
        pulse(13'h100);
        repeat (2) @(posedge mclk);
        chk({nClr - n0, lpState, cpuClkEn, periphClkEn, wdogEn}, 32'h2b);
        @(posedge mclk) req <= 6'h1;
        take(13'h0, sielp_pkg::VEC_IRQ);
        chk(lpState, 32'h0);
        @(posedge mclk) req <= '0;
        pulse(13'h100);
        @(posedge mclk) breakReq <= 1'b1;
        repeat (3) @(posedge mclk);
        breakReq <= 1'b0;
        rd(sielp_pkg::BST_OFF);
        chk(d & 32'h2, 32'h2);
        // Stop twice: short recovery, then long recovery with the double clock kept running.
        for (int k = 0; k < 2; k++) begin
            wr(sielp_pkg::CFG_OFF, k ? 32'h4 : 32'h2);
            pulse(13'h200);
            repeat (2) @(posedge mclk);
            chk({lpState, busX2En, busX4En}, {28'h0, 2'h2, k[0], 1'b0});
            n0 = nTake;
            cnt = 0;
            @(posedge mclk) req <= 6'h1;
            while (lpState !== 2'h0) begin
                @(posedge mclk);
                cnt++;
            end
            chk(nTake, n0);
            cnt -= k ? RecL : 32;
            chk(32'(cnt >= 0 && cnt <= 3), 32'h1);
            @(posedge mclk) req <= '0;
        end
        // A low clock enable must swallow a wait pulse.
        @(posedge mclk) clkEn <= 1'b0;
        pulse(13'h100);
        @(posedge mclk) clkEn <= 1'b1;
        chk({lpState, clearIMask}, 32'h0); // Clock enable freezes state.
        finish_test();
    end
endmodule : tb_top
